// file: lcdhi_checker.sv
// Port-level assertions for lcdhi_top.
// Assumes binding to lcdhi_top; sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module lcdhi_checker (
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  input wire logic        par_select_i,
  input wire logic        clock_source_select_i,
  input wire logic        external_display_clock_i,
  input wire logic        d_oe_o,
  input wire logic        unit_valid_o,
  input wire logic        unit_ready_i,
  input wire logic [10:0] unit_data_o,
  input wire logic        mem_rd_req_o,
  input wire logic        disp_clk_o,
  input wire logic        duty67_i,
  input wire logic [6:0]  col_i,
  input wire logic [6:0]  com_i,
  input wire logic [8:0]  seg_base_o,
  input wire logic        col_valid_o,
  input wire logic        com_valid_o
);
  // ****
  // Properties
  // ****
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire ok67 = (com_i >= 7'h08 && com_i <= 7'h29) || (com_i >= 7'h32 && com_i <= 7'h52);
  sequence s_ser_idle;
    !par_select_i [*4];
  endsequence
  sequence s_ext_lo;
    (!clock_source_select_i && !external_display_clock_i) [*6];
  endsequence
  sequence s_ext_hi;
    (!clock_source_select_i && external_display_clock_i) [*6];
  endsequence
  a_seg_duty67: assert property (duty67_i && col_i <= 7'h61 |=> col_valid_o
    && seg_base_o == 9'h009 + 9'h003 * $past(col_i)) else $error("bad 1/67 segment base");
  a_seg_duty82: assert property (!duty67_i && col_i <= 7'h67 |=> col_valid_o
    && seg_base_o == 9'h003 * $past(col_i)) else $error("bad 1/82 segment base");
  a_col_out: assert property ((duty67_i ? col_i > 7'h61 : col_i > 7'h67)
    |=> !col_valid_o) else $error("column beyond range marked valid");
  a_com_duty67: assert property (duty67_i |=> com_valid_o == $past(ok67))
    else $error("bad 1/67 common validity");
  a_com_duty82: assert property (!duty67_i |=> com_valid_o ==
    ($past(com_i) >= 7'h01 && $past(com_i) <= 7'h52)) else $error("bad 1/82 common");
  a_ext_low: assert property (s_ext_lo |-> !disp_clk_o)
    else $error("display clock not following low external clock");
  a_ext_high: assert property (s_ext_hi |-> disp_clk_o)
    else $error("display clock not following high external clock");
  a_serial_no_read: assert property (s_ser_idle |-> !d_oe_o)
    else $error("data pins driven in serial mode");
  a_unit_hold: assert property (unit_valid_o && !unit_ready_i |=> unit_valid_o
    && $stable(unit_data_o)) else $error("unit dropped or changed while stalled");
  a_fetch_pulse: assert property (mem_rd_req_o |=> !mem_rd_req_o)
    else $error("memory fetch longer than one cycle");
endmodule // lcdhi_checker
bind lcdhi_top lcdhi_checker lcdhi_checker_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .par_select_i(par_select_i), .clock_source_select_i(clock_source_select_i),
  .external_display_clock_i(external_display_clock_i), .d_oe_o(d_oe_o),
  .unit_valid_o(unit_valid_o), .unit_ready_i(unit_ready_i), .unit_data_o(unit_data_o),
  .mem_rd_req_o(mem_rd_req_o), .disp_clk_o(disp_clk_o), .duty67_i(duty67_i),
  .col_i(col_i), .com_i(com_i), .seg_base_o(seg_base_o), .col_valid_o(col_valid_o),
  .com_valid_o(com_valid_o));
`default_nettype wire

// file: lcdhi_defines.vh
// Constants for the display driver host interface: field positions,
// command codes, serial unit lengths, timing and panel mapping limits.
// Assumes inclusion by bare name from the design files of this block.
//
// Operation
// - Static format pin picks 9-bit or 8-bit serial
// - Format pin high means 8-bit, low 9-bit
// - 9-bit unit: flag bit then eight data
// - 8-bit unit: data/command from separate pin
// - Sample serial data on rising serial clock
// - Chip select high discards partial unit
// - Unit after abort counts as first parameter (here an abort leaves the parameter index as it was)
// - No display memory readback over serial
// - Type pin high parallel, low serial
// - Style pin high 80-style, low 68-style
// - Data/command pin high data, low command
// - Parallel access via holding register, no waits
// - Data after memory-write command goes to memory
// - First read after memory-read is dummy
// - Clock-select low external, high internal oscillator
// - 1/67 duty: columns 0-97 on centred segments
// - 1/82 duty: columns 0-103 on all segments
// - 1/67 duty: commons 8-41, 50-82 valid
// - 1/82 duty: all commons valid
`ifndef LCDHI_DEFINES_VH
`define LCDHI_DEFINES_VH

// Serial unit lengths
`define LCDHI_UNIT9        4'h9
`define LCDHI_UNIT8        4'h8

// Unit word layout pushed into the FIFO
`define LCDHI_WORD_W       11
`define LCDHI_WB_MEM       10
`define LCDHI_WB_DATA      9
`define LCDHI_WB_FIRST     8

// Command codes (plain defaults)
`define LCDHI_CMD_MEMWR    8'h5C
`define LCDHI_CMD_MEMRD    8'h5D
`define LCDHI_DUMMY_BYTE   8'h00

// Synchroniser bundle positions
`define LCDHI_SY_W         17
`define LCDHI_SY_CSN       0
`define LCDHI_SY_RD        1
`define LCDHI_SY_WR        2
`define LCDHI_SY_DC        3
`define LCDHI_SY_EXTCLK    4
`define LCDHI_SY_PAR       5
`define LCDHI_SY_STYLE     6
`define LCDHI_SY_FMT       7
`define LCDHI_SY_CLS       8
`define LCDHI_SY_D         9

// Internal oscillator half period in core cycles
`define LCDHI_OSC_HALF     8'h10

// Panel mapping
`define LCDHI_COL_MAX67    7'h61
`define LCDHI_COL_MAX82    7'h67
`define LCDHI_SEG_OFS67    9'h009
`define LCDHI_COM_LO_A     7'h08
`define LCDHI_COM_HI_A     7'h29
`define LCDHI_COM_LO_B     7'h32
`define LCDHI_COM_LAST     7'h52
`define LCDHI_COM_FIRST    7'h01

`endif

// file: lcdhi_fifo.v
// Synchronous FIFO with valid/ready on both sides for host units.
// Assumes a single clock and a synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none

module lcdhi_fifo #(
  parameter W  = 11,
  parameter AW = 4
) (
  input  wire         core_clk_i,
  input  wire         rst_n_i,
  input  wire         in_valid_i,
  output wire         in_ready_o,
  input  wire [W-1:0] in_data_i,
  output wire         out_valid_o,
  input  wire         out_ready_i,
  output wire [W-1:0] out_data_o
);

  localparam DEPTH = 1 << AW;

  reg [W-1:0]  mem_r [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0]   cnt_r;
  wire         push;
  wire         pop;

  // Count reaches its top bit only when all DEPTH entries are taken
  assign in_ready_o  = ~cnt_r[AW];
  assign out_valid_o = (cnt_r != {(AW+1){1'b0}});
  assign out_data_o  = mem_r[rp_r];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge core_clk_i)
  begin
    if (push)
    begin
      mem_r[wp_r] <= in_data_i;
    end
  end

  always @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop)
      begin
        rp_r <= rp_r + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_r <= cnt_r + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

endmodule // lcdhi_fifo

`default_nettype wire

// file: lcdhi_host_model.sv
// Serial host model: sends 8- or 9-bit units, optionally cut short.
// Assumes the bench routes its pins only while serial mode is chosen.
`timescale 1ns/1ns
`default_nettype none
module lcdhi_host_model (
  output var logic cs_n_o,
  output var logic sclk_o,
  output var logic sdat_o,
  output var logic dc_o
);
  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdat_o = 1'b0;
    dc_o = 1'b0;
  end
  // Stop below n aborts the unit by raising select early
  task automatic send(input int n, input logic [8:0] v, input logic dc, input int stop);
    int i;
    cs_n_o = 1'b0;
    dc_o = dc;
    for (i = n - 1; i >= n - stop; i--)
    begin
      sclk_o = 1'b0;
      sdat_o = v[i];
      #32;
      sclk_o = 1'b1;
      #32;
    end
    sclk_o = 1'b0;
    // Released line shows a changed level, never the last bit
    sdat_o = ~sdat_o;
    #32;
    cs_n_o = 1'b1;
    dc_o = ~dc_o;
    #64;
  endtask
endmodule // lcdhi_host_model
`default_nettype wire

// file: lcdhi_top.v
// Host interface of a colour display driver: serial 8/9-bit and
// parallel 80/68-style access, command tracking, dummy-read holding
// register, display clock selection and panel output mapping.
// Assumes all host pins are asynchronous to core_clk_i and that the
// display core drains units from the FIFO and answers memory reads
// one cycle after a read request.
`timescale 1ns/1ns
`default_nettype none
`include "lcdhi_defines.vh"

module lcdhi_top #(
  parameter FIFO_AW = 4
) (
  input  wire                     core_clk_i,
  input  wire                     rst_n_i,
  // Host pins
  input  wire                     cs_n_i,
  input  wire [7:0]               d_i,
  output wire [7:0]               d_o,
  output wire                     d_oe_o,
  input  wire                     par_select_i,
  input  wire                     bus_style_select_i,
  input  wire                     serial_format_select_i,
  input  wire                     data_command_pin_i,
  input  wire                     rd_n_i,
  input  wire                     wr_n_i,
  input  wire                     clock_source_select_i,
  input  wire                     external_display_clock_i,
  output wire                     host_ready_o,
  // Core side unit stream
  output wire                     unit_valid_o,
  input  wire                     unit_ready_i,
  output wire [`LCDHI_WORD_W-1:0] unit_data_o,
  // Core side memory read port
  output reg                      mem_rd_req_o,
  input  wire [7:0]               mem_rd_data_i,
  output reg                      mem_rd_start_o,
  // Display clock and panel mapping
  output reg                      disp_clk_o,
  input  wire                     duty67_i,
  input  wire [6:0]               col_i,
  input  wire [6:0]               com_i,
  output reg  [8:0]               seg_base_o,
  output reg                      col_valid_o,
  output reg                      com_valid_o
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  wire [`LCDHI_SY_W-1:0] pins;
  reg  [`LCDHI_SY_W-1:0] sy_a_r;
  reg  [`LCDHI_SY_W-1:0] sy_b_r;
  reg  [`LCDHI_SY_W-1:0] sy_c_r;

  assign pins = {d_i, clock_source_select_i, serial_format_select_i,
                 bus_style_select_i, par_select_i, external_display_clock_i,
                 data_command_pin_i, wr_n_i, rd_n_i, cs_n_i};

  always @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      sy_a_r <= {`LCDHI_SY_W{1'b1}};
      sy_b_r <= {`LCDHI_SY_W{1'b1}};
      sy_c_r <= {`LCDHI_SY_W{1'b1}};
    end
    else
    begin
      sy_a_r <= pins;
      sy_b_r <= sy_a_r;
      sy_c_r <= sy_b_r;
    end
  end

  wire       cs_act = ~sy_b_r[`LCDHI_SY_CSN];
  wire       par    = sy_b_r[`LCDHI_SY_PAR];
  wire       sty80  = sy_b_r[`LCDHI_SY_STYLE];
  wire       fmt8   = sy_b_r[`LCDHI_SY_FMT];
  wire       dc_pin = sy_b_r[`LCDHI_SY_DC];
  wire [7:0] dbus   = sy_b_r[`LCDHI_SY_D +: 8];
  wire       sclk   = sy_b_r[`LCDHI_SY_D + 7];
  wire       sclk_q = sy_c_r[`LCDHI_SY_D + 7];
  wire       serial_data_line    = sy_b_r[`LCDHI_SY_D + 6];
  wire       rdp    = sy_b_r[`LCDHI_SY_RD];
  wire       wrp    = sy_b_r[`LCDHI_SY_WR];

  // ****************************************************************
  // Serial receiver
  // ****************************************************************
  reg  [3:0] bit_cnt_r;
  reg  [8:0] shift_r;
  wire [3:0] unit_len;
  wire       sclk_rise;
  wire [8:0] shift_nxt;
  wire       ser_done;

  assign unit_len  = fmt8 ? `LCDHI_UNIT8 : `LCDHI_UNIT9;
  assign sclk_rise = ~par & cs_act & sclk & ~sclk_q;
  assign shift_nxt = {shift_r[7:0], serial_data_line};
  assign ser_done  = sclk_rise & (bit_cnt_r == unit_len - 4'h1);

  always @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      bit_cnt_r <= 4'h0;
      shift_r   <= 9'h000;
    end
    else if (!cs_act || par)
    begin
      bit_cnt_r <= 4'h0;
    end
    else if (sclk_rise)
    begin
      shift_r   <= shift_nxt;
      bit_cnt_r <= ser_done ? 4'h0 : bit_cnt_r + 4'h1;
    end
  end

  // ****************************************************************
  // Parallel strobes
  // ****************************************************************
  reg  wr_act_q_r;
  reg  rd_act_q_r;
  wire wr_act;
  wire rd_act;
  wire wr_end;
  wire rd_end;

  // 80-style: active-low strobes; 68-style: E high with R/W direction
  assign wr_act = par & cs_act & (sty80 ? ~wrp : (rdp & ~wrp));
  assign rd_act = par & cs_act & (sty80 ? ~rdp : (rdp & wrp));
  assign wr_end = wr_act_q_r & ~wr_act;
  assign rd_end = rd_act_q_r & ~rd_act;

  always @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_act_q_r <= 1'b0;
      rd_act_q_r <= 1'b0;
    end
    else
    begin
      wr_act_q_r <= wr_act;
      rd_act_q_r <= rd_act;
    end
  end

  // ****************************************************************
  // Unit decode and command tracking
  // ****************************************************************
  reg        unit_v;
  reg        unit_is_data;
  reg  [7:0] unit_byte;
  reg        par_idx_zero_r;
  reg        memwr_mode_r;
  reg        memrd_mode_r;
  reg        wr_latch_r;
  reg  [7:0] wr_byte_r;
  reg        wr_dc_r;
  wire       fifo_in_ready;

  always @*
  begin
    unit_v       = 1'b0;
    unit_is_data = 1'b0;
    unit_byte    = 8'h00;
    if (ser_done)
    begin
      unit_v = 1'b1;
      if (fmt8)
      begin
        unit_is_data = dc_pin;
        unit_byte    = shift_nxt[7:0];
      end
      else
      begin
        unit_is_data = shift_nxt[8];
        unit_byte    = shift_nxt[7:0];
      end
    end
    else if (wr_latch_r)
    begin
      unit_v       = 1'b1;
      unit_is_data = wr_dc_r;
      unit_byte    = wr_byte_r;
    end
  end

  // Data and data/command level are caught while the strobe is still active
  always @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_latch_r <= 1'b0;
      wr_byte_r  <= 8'h00;
      wr_dc_r    <= 1'b0;
    end
    else
    begin
      wr_latch_r <= wr_end;
      if (wr_act)
      begin
        wr_byte_r <= dbus;
        wr_dc_r   <= dc_pin;
      end
    end
  end

  always @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      par_idx_zero_r <= 1'b1;
      memwr_mode_r   <= 1'b0;
      memrd_mode_r   <= 1'b0;
    end
    else if (unit_v && fifo_in_ready)
    begin
      if (!unit_is_data)
      begin
        par_idx_zero_r <= 1'b1;
        memwr_mode_r   <= (unit_byte == `LCDHI_CMD_MEMWR);
        memrd_mode_r   <= (unit_byte == `LCDHI_CMD_MEMRD);
      end
      else
      begin
        // Only a complete unit moves on; an aborted one never gets here
        par_idx_zero_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Unit FIFO toward the display core
  // ****************************************************************
  wire [`LCDHI_WORD_W-1:0] fifo_in_data;

  assign fifo_in_data = {memwr_mode_r & unit_is_data, unit_is_data,
                         par_idx_zero_r & unit_is_data, unit_byte};
  // No wait states on the pins: host must honour host_ready_o
  assign host_ready_o = fifo_in_ready;

  lcdhi_fifo #(
    .W  (`LCDHI_WORD_W),
    .AW (FIFO_AW)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (unit_v),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (fifo_in_data),
    .out_valid_o (unit_valid_o),
    .out_ready_i (unit_ready_i),
    .out_data_o  (unit_data_o)
  );

  // ****************************************************************
  // Read holding register
  // ****************************************************************
  reg  [7:0] hold_r;
  reg        fetch_pend_r;
  reg        oe_r;

  // Outputs only in parallel mode; serial can never read memory
  assign d_o    = hold_r;
  assign d_oe_o = oe_r;

  always @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      hold_r         <= `LCDHI_DUMMY_BYTE;
      fetch_pend_r   <= 1'b0;
      oe_r           <= 1'b0;
      mem_rd_req_o   <= 1'b0;
      mem_rd_start_o <= 1'b0;
    end
    else
    begin
      oe_r           <= rd_act;
      mem_rd_req_o   <= rd_end & memrd_mode_r;
      fetch_pend_r   <= mem_rd_req_o;
      mem_rd_start_o <= 1'b0;
      if (unit_v && fifo_in_ready && !unit_is_data &&
          unit_byte == `LCDHI_CMD_MEMRD)
      begin
        hold_r         <= `LCDHI_DUMMY_BYTE;
        mem_rd_start_o <= 1'b1;
      end
      else if (fetch_pend_r)
      begin
        hold_r <= mem_rd_data_i;
      end
    end
  end

  // ****************************************************************
  // Display clock selection
  // ****************************************************************
  reg [7:0] osc_cnt_r;
  reg       osc_r;

  always @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      osc_cnt_r  <= 8'h00;
      osc_r      <= 1'b0;
      disp_clk_o <= 1'b0;
    end
    else
    begin
      if (osc_cnt_r == `LCDHI_OSC_HALF - 8'h01)
      begin
        osc_cnt_r <= 8'h00;
        osc_r     <= ~osc_r;
      end
      else
      begin
        osc_cnt_r <= osc_cnt_r + 8'h01;
      end
      disp_clk_o <= sy_b_r[`LCDHI_SY_CLS] ? osc_r
                                          : sy_b_r[`LCDHI_SY_EXTCLK];
    end
  end

  // ****************************************************************
  // Panel output mapping
  // ****************************************************************
  wire [8:0] col3 = {2'b00, col_i} + {1'b0, col_i, 1'b0};

  always @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      seg_base_o  <= 9'h000;
      col_valid_o <= 1'b0;
      com_valid_o <= 1'b0;
    end
    else if (duty67_i)
    begin
      seg_base_o  <= col3 + `LCDHI_SEG_OFS67;
      col_valid_o <= (col_i <= `LCDHI_COL_MAX67);
      com_valid_o <= ((com_i >= `LCDHI_COM_LO_A) && (com_i <= `LCDHI_COM_HI_A)) ||
                     ((com_i >= `LCDHI_COM_LO_B) && (com_i <= `LCDHI_COM_LAST));
    end
    else
    begin
      seg_base_o  <= col3;
      col_valid_o <= (col_i <= `LCDHI_COL_MAX82);
      com_valid_o <= (com_i >= `LCDHI_COM_FIRST) &&
                     (com_i <= `LCDHI_COM_LAST);
    end
  end

endmodule // lcdhi_top

`default_nettype wire

// file: tb.sv
// Self-checking bench for lcdhi_top with a serial host model.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ns
`default_nettype none
`include "lcdhi_defines.vh"
module tb;
  logic        clk = 0, rst_n = 0, par = 0, style = 1, fmt = 0, clock_source_select = 1, ext = 0;
  logic        duty = 0, p_cs = 1, p_dc = 0, rd_n = 1, wr_n = 1, ready = 0, dsave;
  logic [7:0]  pd = 8'h00, mem_b = 8'h00;
  logic [6:0]  col = 7'h00, com = 7'h01;
  wire         m_cs, m_sclk, m_sdat, m_dc, d_oe, hrdy, uv, rreq, rstart, cv, mv, dclk;
  wire  [7:0]  d_o;
  wire  [10:0] ud;
  wire  [8:0]  seg;
  int          n_fail = 0, n_checks = 0, cyc = 0, i;
  logic [25:0] tab [10] = '{{1'h1, 7'h00, 7'h08, 2'h3, 9'h009},
    {1'h1, 7'h61, 7'h29, 2'h3, 9'h12C}, {1'h1, 7'h62, 7'h2A, 2'h0, 9'h000},
    {1'h1, 7'h32, 7'h07, 2'h2, 9'h09F}, {1'h1, 7'h01, 7'h32, 2'h3, 9'h00C},
    {1'h1, 7'h02, 7'h31, 2'h2, 9'h00F}, {1'h1, 7'h02, 7'h52, 2'h3, 9'h00F},
    {1'h0, 7'h00, 7'h01, 2'h3, 9'h000}, {1'h0, 7'h67, 7'h52, 2'h3, 9'h135},
    {1'h0, 7'h68, 7'h53, 2'h0, 9'h000}};
  logic [10:0] ser_exp [8] = '{11'h02A, 11'h311, 11'h222, 11'h02B, 11'h333,
    11'h05C, 11'h7A5, 11'h65A};
  always #2 clk = ~clk;
  // External clock of 40 ns halves, moved on the core clock edge; frozen when internal
  always @(posedge clk) if (!clock_source_select && cyc % 10 == 9) ext <= ~ext;
  // Core memory: restart on read command, next byte per fetch
  always @(posedge clk)
    if (rstart) mem_b <= 8'hC0;
    else if (rreq) mem_b <= mem_b + 8'h01;
  lcdhi_host_model host (.cs_n_o(m_cs), .sclk_o(m_sclk), .sdat_o(m_sdat), .dc_o(m_dc));
  lcdhi_top lcdhi_top_i (.core_clk_i(clk), .rst_n_i(rst_n), .cs_n_i(par ? p_cs : m_cs),
    .d_i(par ? pd : {m_sclk, m_sdat, 6'h00}), .d_o(d_o), .d_oe_o(d_oe), .par_select_i(par),
    .bus_style_select_i(style), .serial_format_select_i(fmt),
    .data_command_pin_i(par ? p_dc : m_dc), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .clock_source_select_i(clock_source_select), .external_display_clock_i(ext), .host_ready_o(hrdy),
    .unit_valid_o(uv), .unit_ready_i(ready), .unit_data_o(ud), .mem_rd_req_o(rreq),
    .mem_rd_data_i(mem_b), .mem_rd_start_o(rstart), .disp_clk_o(dclk), .duty67_i(duty),
    .col_i(col), .com_i(com), .seg_base_o(seg), .col_valid_o(cv), .com_valid_o(mv));
  // ****
  // Tasks
  // ****
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic pop(input logic [10:0] e);
    int k;
    k = 0;
    while (uv !== 1'b1 && k < 400)
    begin
      step();
      k++;
    end
    chk(ud, e, "unit");
    ready = 1;
    step();
    ready = 0;
    step();
  endtask
  task automatic pw(input logic dc, input logic [7:0] v);
    pd = v;
    p_dc = dc;
    {rd_n, wr_n} = 2'h2;
    step(4);
    {rd_n, wr_n} = style ? 2'h3 : 2'h1;
    step(4);
  endtask
  task automatic pr(input logic [7:0] e);
    {rd_n, wr_n} = style ? 2'h1 : 2'h3;
    step(5);
    chk({2'h0, d_oe, d_o}, {3'h1, e}, "read");
    {rd_n, wr_n} = style ? 2'h3 : 2'h1;
    step(6);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      summarize();
    end
  end
  // ****
  // Sequence
  // ****
  initial
  begin
    repeat (12) @(posedge clk);
    #1 rst_n = 1;
    step();
    chk({8'h00, hrdy, uv, d_oe}, 11'h004, "reset");
    $display("test reset done");
    foreach (tab[i])
    begin
      {duty, col, com} = tab[i][25:11];
      step(2);
      chk({cv, mv, tab[i][10] ? seg : 9'h000}, tab[i][10:0], "map");
    end
    clock_source_select = 0;
    step(60);
    clock_source_select = 1;
    step(4);
    dsave = dclk;
    step(`LCDHI_OSC_HALF);
    chk({10'h000, dclk}, {10'h000, ~dsave}, "internal clock");
    $display("test map and clock done");
    // Read strobe parked low: serial mode must still leave the pins undriven
    rd_n = 0;
    host.send(9, 9'h02A, 1'h1, 9);
    host.send(9, 9'h111, 1'h0, 9);
    host.send(9, 9'h122, 1'h0, 9);
    host.send(9, 9'h02B, 1'h0, 9);
    host.send(9, 9'h1AA, 1'h0, 4);
    host.send(9, 9'h133, 1'h0, 9);
    step();
    fmt = 1;
    host.send(8, 9'h05C, 1'h0, 8);
    host.send(8, 9'h0A5, 1'h1, 8);
    host.send(8, 9'h05A, 1'h1, 8);
    step();
    foreach (ser_exp[i]) pop(ser_exp[i]);
    chk({10'h000, d_oe}, 11'h000, "serial read");
    $display("test serial done");
    rd_n = 1;
    par = 1;
    p_cs = 0;
    step(4);
    pw(0, 8'h5D);
    pop(11'h05D);
    pr(8'h00);
    pr(8'hC1);
    pr(8'hC2);
    style = 0;
    {rd_n, wr_n} = 2'h1;
    step(4);
    pw(0, 8'h5C);
    pw(1, 8'h77);
    pop(11'h05C);
    pop(11'h777);
    for (i = 0; i < 17; i++) pw(1, i[7:0]);
    chk({10'h000, hrdy}, 11'h000, "full");
    for (i = 0; i < 16; i++) pop({3'h6, i[7:0]});
    step(2);
    chk({10'h000, uv}, 11'h000, "empty");
    pw(0, 8'h5D);
    pop(11'h05D);
    pr(8'h00);
    pr(8'hC1);
    $display("test parallel done");
    summarize();
  end
endmodule // tb
`default_nettype wire
